// ===== rtl/timer_ctl_pkg.sv
// Constants and state types for the timer count source and clear control
package timer_ctl_pkg;
   localparam int NCH = 3;
   localparam int CNT_W = 16;
   localparam int PRE_W = 10;
   localparam int NEXT = 4;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL0 = 4'h0;
   localparam logic [3:0] IDX_CTRL1 = 4'h1;
   localparam logic [3:0] IDX_CTRL2 = 4'h2;
   localparam logic [3:0] IDX_SYNC = 4'h3;
   localparam logic [3:0] IDX_CNT0 = 4'h4;
   localparam logic [3:0] IDX_CNT1 = 4'h5;
   localparam logic [3:0] IDX_CNT2 = 4'h6;
   // Control register fields
   localparam int RES_BIT = 7;
   localparam int CLR_HI = 6;
   localparam int CLR_LO = 5;
   localparam int EDGE_HI = 4;
   localparam int EDGE_LO = 3;
   localparam int PSC_HI = 2;
   localparam int PSC_LO = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL12_MASK = 8'h7f;
   localparam logic [2:0] SYNC_RST = 3'h0;
   // Clear select codes
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_A = 2'h1;
   localparam logic [1:0] CLR_B = 2'h2;
   localparam logic [1:0] CLR_SYNC = 2'h3;
   // Edge select codes; high bit set means both edges
   localparam logic [1:0] EDGE_RISE = 2'h0;
   localparam logic [1:0] EDGE_FALL = 2'h1;
   localparam logic [1:0] EDGE_BOTH = 2'h2;
   // Prescaler select codes
   localparam logic [2:0] PSC_DIV1 = 3'h0;
   localparam logic [2:0] PSC_DIV4 = 3'h1;
   localparam logic [2:0] PSC_DIV16 = 3'h2;
   localparam logic [2:0] PSC_DIV64 = 3'h3;
   localparam logic [2:0] PSC_EXT_A = 3'h4;
   localparam logic [2:0] PSC_EXT_B = 3'h5;
   localparam logic [2:0] PSC_SEL6 = 3'h6;
   localparam logic [2:0] PSC_SEL7 = 3'h7;
   // Free-running prescaler bit whose edges give each tap
   localparam int TAP4 = 1;
   localparam int TAP16 = 3;
   localparam int TAP64 = 5;
   localparam int TAP256 = 7;
   localparam int TAP1024 = 9;
   // External pin indices
   localparam int PIN_A = 0;
   localparam int PIN_B = 1;
   localparam int PIN_C = 2;
   localparam int PIN_D = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [NCH-1:0][7:0] ctrl;
      logic [NCH-1:0] sync_en;
      logic [NCH-1:0][CNT_W-1:0] cnt;
      logic [PRE_W-1:0] pre;
      logic [PRE_W-1:0] pre_d;
      logic [NEXT-1:0] ext_s1;
      logic [NEXT-1:0] ext_s2;
      logic [NEXT-1:0] ext_s3;
      logic awready;
      logic wready;
      logic aw_have;
      logic w_have;
      logic [ADDR_W-1:0] aw_addr;
      logic [DATA_W-1:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } state_t;

   localparam state_t STATE_RST = '0;
endpackage

// ===== rtl/timer_count_control.sv
// Three-channel timer count source, edge and clear control with AXI4-Lite
// Notes on behaviour
// R1 - Clear field: none, on A, on B, synchronous
// R2 - Synchronous clear follows sync-enabled channels only
// R3 - Channel 1,2 bit 7 reads zero, ignores writes
// R4 - Edge field: rising, falling, or both edges
// R5 - Both edges of a tap count at half
// R6 - Edge select ignored for undivided and overflow
// R7 - Phase counting overrides edge select on 1,2
// R8 - Channel 0 sources: taps and four pins
// R9 - Channel 1 sources: taps, pins, 256, overflow
// R10 - Channel 2 sources: taps, three pins, 1024
// R11 - Phase counting overrides prescaler on 1,2
// R12 - Each channel has its own source mux
// R13 - Reset or standby zeroes control registers
// R14 - Count one per qualifying edge, pins synchronised
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module timer_count_control #(
   parameter int P_CNT_W = 16
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_standby,
   // AXI4-Lite slave
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Timer side
   input wire logic [3:0] i_ext_pin,
   input wire logic [2:0] i_phase_mode,
   input wire logic [2:0] i_phase_up,
   input wire logic [2:0] i_phase_down,
   input wire logic [2:0] i_match_a,
   input wire logic [2:0] i_match_b,
   input wire logic i_match_c,
   input wire logic i_match_d,
   output logic [2:0][15:0] o_timer_count
);
   localparam int DW = timer_ctl_pkg::DATA_W;

   if (P_CNT_W != timer_ctl_pkg::CNT_W)
   begin : g_width_check
      $error("Counter width must match the package width");
   end

   timer_ctl_pkg::state_t state_reg;
   timer_ctl_pkg::state_t state_next;

   // Returns {valid, index}; only aligned words inside the map are valid
   function automatic logic [4:0] decode(input logic [7:0] a);
      logic ok;
      ok = (a[1:0] == 2'h0) && (a[7:6] == 2'h0)
         && (a[5:2] <= timer_ctl_pkg::IDX_CNT2);
      return {ok, a[5:2]};
   endfunction

   function automatic logic pick_edge(input logic [1:0] es,
      input logic rise, input logic fall);
      logic r;
      r = es[1] ? (rise | fall) : (es[0] ? fall : rise); // see R4
      return r;
   endfunction

   logic [timer_ctl_pkg::NEXT-1:0] pin_rise;
   logic [timer_ctl_pkg::NEXT-1:0] pin_fall;
   logic [timer_ctl_pkg::PRE_W-1:0] tap_rise;
   logic [timer_ctl_pkg::PRE_W-1:0] tap_fall;
   logic [2:0] tick;
   logic [2:0] up;
   logic [2:0] down;
   logic [2:0] wrap;
   logic [2:0] own_clr;
   logic sync_any;
   logic [1:0] es;
   logic [1:0] clr_sel;
   logic ma;
   logic mb;
   logic [4:0] dec;
   logic [4:0] rdec;

   always_comb
   begin
      state_next = state_reg;
      pin_rise = '0;
      pin_fall = '0;
      tap_rise = '0;
      tap_fall = '0;
      tick = '0;
      up = '0;
      down = '0;
      wrap = '0;
      own_clr = '0;
      sync_any = 1'b0;
      es = '0;
      clr_sel = '0;
      ma = 1'b0;
      mb = 1'b0;
      dec = '0;
      rdec = '0;
      // Only the second and third stages feed edge detection
      state_next.ext_s1 = i_ext_pin; // see R14
      state_next.ext_s2 = state_reg.ext_s1;
      state_next.ext_s3 = state_reg.ext_s2;
      pin_rise = state_reg.ext_s2 & ~state_reg.ext_s3;
      pin_fall = ~state_reg.ext_s2 & state_reg.ext_s3;
      // Tap edges come from one shared prescaler, so taps stay in phase
      state_next.pre = state_reg.pre + 1'b1;
      state_next.pre_d = state_reg.pre;
      tap_rise = state_reg.pre & ~state_reg.pre_d;
      tap_fall = ~state_reg.pre & state_reg.pre_d;

      for (int ch = 0; ch < timer_ctl_pkg::NCH; ch++)
      begin
         clr_sel = state_reg.ctrl[ch][timer_ctl_pkg::CLR_HI:
            timer_ctl_pkg::CLR_LO];
         ma = (ch == 0 && state_reg.ctrl[0][timer_ctl_pkg::RES_BIT])
            ? i_match_c : i_match_a[ch];
         mb = (ch == 0 && state_reg.ctrl[0][timer_ctl_pkg::RES_BIT])
            ? i_match_d : i_match_b[ch];
         own_clr[ch] = (clr_sel == timer_ctl_pkg::CLR_A && ma)
            || (clr_sel == timer_ctl_pkg::CLR_B && mb); // see R1
         if (state_reg.sync_en[ch] && own_clr[ch])
         begin
            sync_any = 1'b1; // see R2
         end
      end

      // Channel 2 first, as its wrap can clock channel 1
      for (int ch = timer_ctl_pkg::NCH - 1; ch >= 0; ch--)
      begin
         es = state_reg.ctrl[ch][timer_ctl_pkg::EDGE_HI:
            timer_ctl_pkg::EDGE_LO];
         case (state_reg.ctrl[ch][timer_ctl_pkg::PSC_HI:
            timer_ctl_pkg::PSC_LO]) // see R12
            timer_ctl_pkg::PSC_DIV1:
               tick[ch] = 1'b1; // see R6
            timer_ctl_pkg::PSC_DIV4:
               tick[ch] = pick_edge(es, tap_rise[timer_ctl_pkg::TAP4],
                  tap_fall[timer_ctl_pkg::TAP4]); // see R5
            timer_ctl_pkg::PSC_DIV16:
               tick[ch] = pick_edge(es, tap_rise[timer_ctl_pkg::TAP16],
                  tap_fall[timer_ctl_pkg::TAP16]);
            timer_ctl_pkg::PSC_DIV64:
               tick[ch] = pick_edge(es, tap_rise[timer_ctl_pkg::TAP64],
                  tap_fall[timer_ctl_pkg::TAP64]);
            timer_ctl_pkg::PSC_EXT_A:
               tick[ch] = pick_edge(es, pin_rise[timer_ctl_pkg::PIN_A],
                  pin_fall[timer_ctl_pkg::PIN_A]);
            timer_ctl_pkg::PSC_EXT_B:
               tick[ch] = pick_edge(es, pin_rise[timer_ctl_pkg::PIN_B],
                  pin_fall[timer_ctl_pkg::PIN_B]);
            timer_ctl_pkg::PSC_SEL6:
               if (ch == 1)
               begin
                  tick[ch] = pick_edge(es,
                     tap_rise[timer_ctl_pkg::TAP256],
                     tap_fall[timer_ctl_pkg::TAP256]); // see R9
               end
               else
               begin
                  tick[ch] = pick_edge(es,
                     pin_rise[timer_ctl_pkg::PIN_C],
                     pin_fall[timer_ctl_pkg::PIN_C]); // see R8, R10
               end
            timer_ctl_pkg::PSC_SEL7:
               if (ch == 0)
               begin
                  tick[ch] = pick_edge(es,
                     pin_rise[timer_ctl_pkg::PIN_D],
                     pin_fall[timer_ctl_pkg::PIN_D]); // see R8
               end
               else if (ch == 1)
               begin
                  tick[ch] = wrap[2]; // see R9, R6
               end
               else
               begin
                  tick[ch] = pick_edge(es,
                     tap_rise[timer_ctl_pkg::TAP1024],
                     tap_fall[timer_ctl_pkg::TAP1024]); // see R10
               end
            default:
               tick[ch] = 1'b0;
         endcase
         if (ch != 0 && i_phase_mode[ch])
         begin
            up[ch] = i_phase_up[ch] & ~i_phase_down[ch]; // see R7, R11
            down[ch] = i_phase_down[ch] & ~i_phase_up[ch];
         end
         else
         begin
            up[ch] = tick[ch];
         end
         wrap[ch] = (up[ch] && (&state_reg.cnt[ch]))
            || (down[ch] && (state_reg.cnt[ch] == '0));
         clr_sel = state_reg.ctrl[ch][timer_ctl_pkg::CLR_HI:
            timer_ctl_pkg::CLR_LO];
         if (own_clr[ch] || (clr_sel == timer_ctl_pkg::CLR_SYNC
            && state_reg.sync_en[ch] && sync_any)) // see R1, R2
         begin
            state_next.cnt[ch] = '0;
         end
         else if (up[ch])
         begin
            state_next.cnt[ch] = state_reg.cnt[ch] + 1'b1; // see R14
         end
         else if (down[ch])
         begin
            state_next.cnt[ch] = state_reg.cnt[ch] - 1'b1;
         end
      end

      // Write channel: address and data taken in either order
      if (state_reg.awready && i_awvalid)
      begin
         state_next.aw_have = 1'b1;
         state_next.aw_addr = i_awaddr;
      end
      if (state_reg.wready && i_wvalid)
      begin
         state_next.w_have = 1'b1;
         state_next.w_data = i_wdata;
         state_next.w_strb = i_wstrb;
      end
      if (state_reg.bvalid && i_bready)
      begin
         state_next.bvalid = 1'b0;
      end
      if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid)
      begin
         dec = decode(state_reg.aw_addr);
         state_next.aw_have = 1'b0;
         state_next.w_have = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp = dec[4] ? timer_ctl_pkg::RESP_OKAY
            : timer_ctl_pkg::RESP_SLVERR;
         // Counters are read-only here; a write to them is ignored
         if (dec[4] && state_reg.w_strb[0])
         begin
            case (dec[3:0])
               timer_ctl_pkg::IDX_CTRL0:
                  state_next.ctrl[0] = state_reg.w_data[7:0];
               timer_ctl_pkg::IDX_CTRL1:
                  state_next.ctrl[1] = state_reg.w_data[7:0]
                     & timer_ctl_pkg::CTRL12_MASK; // see R3
               timer_ctl_pkg::IDX_CTRL2:
                  state_next.ctrl[2] = state_reg.w_data[7:0]
                     & timer_ctl_pkg::CTRL12_MASK; // see R3
               timer_ctl_pkg::IDX_SYNC:
                  state_next.sync_en = state_reg.w_data[2:0];
               default:
                  state_next.sync_en = state_next.sync_en;
            endcase
         end
      end
      state_next.awready = !state_next.aw_have;
      state_next.wready = !state_next.w_have;

      // Read channel
      if (state_reg.rvalid && i_rready)
      begin
         state_next.rvalid = 1'b0;
      end
      if (state_reg.arready && i_arvalid)
      begin
         rdec = decode(i_araddr);
         state_next.rvalid = 1'b1;
         state_next.rresp = rdec[4] ? timer_ctl_pkg::RESP_OKAY
            : timer_ctl_pkg::RESP_SLVERR;
         state_next.rdata = '0;
         if (rdec[4])
         begin
            case (rdec[3:0])
               timer_ctl_pkg::IDX_CTRL0:
                  state_next.rdata = DW'(state_reg.ctrl[0]);
               timer_ctl_pkg::IDX_CTRL1:
                  state_next.rdata = DW'(state_reg.ctrl[1]);
               timer_ctl_pkg::IDX_CTRL2:
                  state_next.rdata = DW'(state_reg.ctrl[2]);
               timer_ctl_pkg::IDX_SYNC:
                  state_next.rdata = DW'(state_reg.sync_en);
               timer_ctl_pkg::IDX_CNT0:
                  state_next.rdata = DW'(state_reg.cnt[0]);
               timer_ctl_pkg::IDX_CNT1:
                  state_next.rdata = DW'(state_reg.cnt[1]);
               default:
                  state_next.rdata = DW'(state_reg.cnt[2]);
            endcase
         end
      end
      state_next.arready = !state_next.rvalid;

      // Standby overrides a write landing in the same cycle
      if (i_standby)
      begin
         for (int ch = 0; ch < timer_ctl_pkg::NCH; ch++)
         begin
            state_next.ctrl[ch] = timer_ctl_pkg::CTRL_RST; // see R13
         end
         state_next.sync_en = timer_ctl_pkg::SYNC_RST;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_reg <= timer_ctl_pkg::STATE_RST; // see R13
      end
      else if (i_ce)
      begin
         state_reg <= state_next;
      end
   end

   assign o_awready = state_reg.awready;
   assign o_wready = state_reg.wready;
   assign o_bresp = state_reg.bresp;
   assign o_bvalid = state_reg.bvalid;
   assign o_arready = state_reg.arready;
   assign o_rdata = state_reg.rdata;
   assign o_rresp = state_reg.rresp;
   assign o_rvalid = state_reg.rvalid;
   assign o_timer_count = state_reg.cnt;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   a_reserved_zero: assert property ( // see R3
      !state_reg.ctrl[1][timer_ctl_pkg::RES_BIT]
      && !state_reg.ctrl[2][timer_ctl_pkg::RES_BIT])
      else $error("Reserved control bit set");
   a_clear_on_a: assert property ( // see R1
      i_ce && !i_standby && state_reg.ctrl[1][6:5] == timer_ctl_pkg::CLR_A
      && i_match_a[1] |=> state_reg.cnt[1] == '0)
      else $error("Channel 1 not cleared on match A");
   a_clear_on_b: assert property ( // see R1
      i_ce && state_reg.ctrl[1][6:5] == timer_ctl_pkg::CLR_B
      && i_match_b[1] |=> state_reg.cnt[1] == '0)
      else $error("Channel 1 not cleared on match B");
   a_sync_clear: assert property ( // see R2
      i_ce && state_reg.sync_en[0] && state_reg.sync_en[1]
      && state_reg.ctrl[0][7:5] == {1'b0, timer_ctl_pkg::CLR_A}
      && i_match_a[0]
      && state_reg.ctrl[1][6:5] == timer_ctl_pkg::CLR_SYNC
      |=> state_reg.cnt[1] == '0)
      else $error("Synchronous clear missed");
   a_sync_member_only: assert property ( // see R2
      i_ce && !state_reg.sync_en[2] && !i_phase_mode[2]
      && state_reg.ctrl[2] == {3'h3, 5'h00}
      |=> state_reg.cnt[2] == $past(state_reg.cnt[2]) + 1'b1)
      else $error("Non-member channel cleared by sync");
   a_phi1_edge_ignored: assert property ( // see R6
      i_ce && state_reg.ctrl[0] == {3'h0, timer_ctl_pkg::EDGE_FALL, 3'h0}
      |=> state_reg.cnt[0] == $past(state_reg.cnt[0]) + 1'b1)
      else $error("Undivided clock not counted every cycle");
   a_both_edge_rate: assert property ( // see R5
      (i_ce && !i_standby
      && state_reg.ctrl[0] == {3'h0, timer_ctl_pkg::EDGE_BOTH, 3'h1})[*4]
      |=> state_reg.cnt[0] == $past(state_reg.cnt[0], 4) + 2'h2)
      else $error("Both edges of divide-by-4 not at half rate");
   a_phase_priority: assert property ( // see R7
      i_ce && i_phase_mode[1] && i_phase_up[1] && !i_phase_down[1]
      && !i_match_a[1] && !i_match_b[1]
      && state_reg.ctrl[1][6:5] != timer_ctl_pkg::CLR_SYNC
      |=> state_reg.cnt[1] == $past(state_reg.cnt[1]) + 1'b1)
      else $error("Phase count did not override source");
   a_standby_reset: assert property ( // see R13
      i_ce && i_standby |=> state_reg.ctrl == '0 && state_reg.sync_en == '0)
      else $error("Standby did not clear control");
   a_write_resp: assert property (
      i_ce && state_reg.aw_have && state_reg.w_have && !state_reg.bvalid
      |=> state_reg.bvalid && !state_reg.aw_have)
      else $error("Write response not issued");
endmodule

// ===== verification/test_timer_count_control.sv
// Self-checking bench for the timer count source and clear control
`timescale 1ns/1ps
module test_timer_count_control;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic standby = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [3:0] ext_pin = 4'h0;
   logic [2:0] phase_mode = 3'h0;
   logic [2:0] phase_up = 3'h0;
   logic [2:0] phase_down = 3'h0;
   logic [2:0] match_a = 3'h0;
   logic [2:0] match_b = 3'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0][15:0] timer_count;
   int num_errors = 0;
   int check_count = 0;

   always #12.5 clk = ~clk;

   timer_count_control #(.P_CNT_W(16)) i_dut (
      .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_standby(standby),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .i_ext_pin(ext_pin),
      .i_phase_mode(phase_mode), .i_phase_up(phase_up),
      .i_phase_down(phase_down), .i_match_a(match_a),
      .i_match_b(match_b), .i_match_c(1'b0), .i_match_d(1'b0),
      .o_timer_count(timer_count)
   );

   function automatic logic [7:0] addr_of(input logic [3:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Address and data are offered together; each drops once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit aw_done;
      bit w_done;
      aw_done = 0;
      w_done = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awvalid && awready === 1'b1)
         begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1)
         begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end while (!(aw_done && w_done));
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      // One idle edge, so a following call never drives bready twice
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      check("bresp", {30'h0, r}, {30'h0, timer_ctl_pkg::RESP_OKAY});
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check("rdata", d, exp);
      check("rresp", {30'h0, r}, {30'h0, er});
   endtask

   // One cycle compare pulse; the counter shows its effect after the edge
   task automatic pulse(input bit on_b, input int ch);
      @(posedge clk);
      if (on_b) match_b[ch] <= 1'b1;
      else match_a[ch] <= 1'b1;
      @(posedge clk);
      match_a <= 3'h0;
      match_b <= 3'h0;
      #1;
   endtask

   // Pin cases count pulses of 4 high, 4 low; others count clock cycles
   task automatic run_case(input int ch, input logic [7:0] ctrl,
                           input int pin, input int n, input logic [15:0] d);
      logic [15:0] c0;
      logic [15:0] dd;
      wr_ok(addr_of(4'(ch)), {24'h00_0000, ctrl});
      cycles(8);
      c0 = timer_count[ch];
      if (pin < 0)
         cycles(n);
      else
      begin
         repeat (n)
         begin
            ext_pin[pin] <= 1'b1;
            cycles(4);
            ext_pin[pin] <= 1'b0;
            cycles(4);
         end
         cycles(6);
      end
      dd = timer_count[ch] - c0;
      check("count delta", {16'h0000, dd}, {16'h0000, d});
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end

   initial
   begin
      logic [15:0] c0;
      logic [1:0] r;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      cycles(2);
      for (int i = 0; i < 4; i++)
         rd_chk(addr_of(4'(i)), 32'h0000_0000, 2'h0);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'h0000_00ff);
      rd_chk(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'h0000_007f, 2'h0);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL2), 32'h0000_0080);
      rd_chk(addr_of(timer_ctl_pkg::IDX_CTRL2), 32'h0000_0000, 2'h0);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL0), 32'h0000_00da);
      rd_chk(addr_of(timer_ctl_pkg::IDX_CTRL0), 32'h0000_00da, 2'h0);
      wr_ok(addr_of(timer_ctl_pkg::IDX_SYNC), 32'h0000_0007);
      rd_chk(8'h40, 32'h0000_0000, timer_ctl_pkg::RESP_SLVERR);
      rd_chk(8'h02, 32'h0000_0000, timer_ctl_pkg::RESP_SLVERR);
      wr(8'h40, 32'h0000_0001, r);
      check("bresp", {30'h0, r}, {30'h0, timer_ctl_pkg::RESP_SLVERR});
      standby <= 1'b1;
      cycles(1);
      standby <= 1'b0;
      for (int i = 0; i < 4; i++)
         rd_chk(addr_of(4'(i)), 32'h0000_0000, 2'h0);
      // Windows are whole tap periods, so the free prescaler phase is moot
      run_case(0, 8'h00, -1, 64, 16'h0040);
      run_case(0, 8'h08, -1, 64, 16'h0040);
      run_case(0, 8'h01, -1, 64, 16'h0010);
      run_case(0, 8'h09, -1, 64, 16'h0010);
      run_case(0, 8'h11, -1, 64, 16'h0020);
      run_case(0, 8'h19, -1, 64, 16'h0020);
      run_case(1, 8'h02, -1, 64, 16'h0004);
      run_case(0, 8'h03, -1, 128, 16'h0002);
      run_case(2, 8'h03, -1, 128, 16'h0002);
      run_case(1, 8'h06, -1, 512, 16'h0002);
      run_case(2, 8'h07, -1, 2048, 16'h0002);
      run_case(2, 8'h00, -1, 64, 16'h0040);
      for (int p = 0; p < 4; p++)
         run_case(0, 8'h04 + 8'(p), p, 5, 16'h0005);
      for (int p = 0; p < 2; p++)
         run_case(1, 8'h04 + 8'(p), p, 5, 16'h0005);
      for (int p = 0; p < 3; p++)
         run_case(2, 8'h04 + 8'(p), p, 5, 16'h0005);
      run_case(0, 8'h14, 0, 5, 16'h000a);
      run_case(0, 8'h0d, 1, 5, 16'h0005);
      // Clear select on channel 1: none, on A, on B
      for (int s = 0; s < 3; s++)
      begin
         wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'(s) << 5);
         cycles(4);
         pulse(0, 1);
         check("clear a", {31'h0, timer_count[1] === 16'h0000}, 32'(s == 1));
         cycles(4);
         pulse(1, 1);
         check("clear b", {31'h0, timer_count[1] === 16'h0000}, 32'(s == 2));
      end
      // Channel 2 asks for sync clear but is left out of the group
      wr_ok(addr_of(timer_ctl_pkg::IDX_SYNC), 32'h0000_0003);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL0), 32'h0000_0020);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'h0000_0060);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL2), 32'h0000_0060);
      cycles(4);
      pulse(0, 0);
      check("sync ch0", {16'h0000, timer_count[0]}, 32'h0000_0000);
      check("sync ch1", {16'h0000, timer_count[1]}, 32'h0000_0000);
      check("sync ch2", {31'h0, timer_count[2] === 16'h0000}, 32'h0000_0000);
      // Phase mode: prescaler and both-edge setting must not count
      wr_ok(addr_of(timer_ctl_pkg::IDX_SYNC), 32'h0000_0000);
      phase_mode <= 3'h2;
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'h0000_0030);
      pulse(0, 1);
      cycles(5);
      check("phase idle", {16'h0000, timer_count[1]}, 32'h0000_0000);
      phase_up[1] <= 1'b1;
      cycles(10);
      phase_up[1] <= 1'b0;
      cycles(2);
      check("phase up", {16'h0000, timer_count[1]}, 32'h0000_000a);
      rd_chk(addr_of(timer_ctl_pkg::IDX_CNT1), 32'h0000_000a, 2'h0);
      // Channel 2 underflow steps channel 1
      phase_mode <= 3'h4;
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL1), 32'h0000_0007);
      wr_ok(addr_of(timer_ctl_pkg::IDX_CTRL2), 32'h0000_0020);
      pulse(0, 2);
      cycles(3);
      c0 = timer_count[1];
      phase_down[2] <= 1'b1;
      cycles(1);
      phase_down[2] <= 1'b0;
      cycles(3);
      check("ch2 wrap", {16'h0000, timer_count[2]}, 32'h0000_ffff);
      check("ch1 step", {16'h0000, timer_count[1] - c0}, 32'h0000_0001);
      // Channel 0 still counts every cycle; only the enabled edges add
      c0 = timer_count[0];
      ce <= 1'b0;
      cycles(6);
      ce <= 1'b1;
      cycles(4);
      check("ce freeze", {16'h0000, timer_count[0] - c0}, 32'h0000_0004);
      tally_and_finish();
   end
endmodule
